// File: hdl/fpss_pkg.sv
// Constants, enumerations and register map of the front panel status sequencer.
// Assumes one 125 MHz clock; all slower rates come from a millisecond enable.
package fpss_pkg;
  // Times in their own units
  localparam int unsigned MS_PER_S = 1000;
  localparam int unsigned LINK_TIMEOUT_S = 10;
  localparam int unsigned IDLE_STEP_S = 5;
  localparam int unsigned FLASH_S = 3;
  localparam int unsigned BLINK_HALF_MS = 250;
  localparam int unsigned REPT_DELAY_MS = 500;
  localparam int unsigned REPT_RATE_MS = 100;
  localparam int unsigned QUEUE_DEPTH = 5;

  // Register byte offsets
  localparam logic [11:0] OFS_CTRL = 12'h000;
  localparam logic [11:0] OFS_STATUS = 12'h004;
  localparam logic [11:0] OFS_QUEUE = 12'h008;
  localparam logic [11:0] OFS_POS = 12'h00C;
  localparam logic [7:0] CTRL_RESET = 8'h1E;

  // Status and queue register field positions
  localparam int unsigned ST_FAULT = 0;
  localparam int unsigned ST_THRESH = 1;
  localparam int unsigned ST_LINK_OK = 2;
  localparam int unsigned ST_IDLE = 3;
  localparam int unsigned ST_SRC = 4;
  localparam int unsigned ST_FLASH = 8;
  localparam int unsigned QU_COUNT = 0;
  localparam int unsigned QU_CLEAR = 0;

  // Page header characters
  localparam logic [7:0] CHAR_SETPT = 8'h53;
  localparam logic [7:0] CHAR_MEAS = 8'h41;
  localparam logic [7:0] CHAR_BAR = 8'h7C;

  // Kinds of edited value
  localparam logic [1:0] KIND_YESNO = 2'h0;
  localparam logic [1:0] KIND_LIST = 2'h1;
  localparam logic [1:0] KIND_NUM = 2'h2;

  typedef enum logic [2:0] {SRC_NAV, SRC_IDLE, SRC_FLASH, SRC_ALARM, SRC_TRIP} fpss_src_e;
  typedef enum logic [2:0] {FL_NONE, FL_ACK, FL_LOCKOUT, FL_FAULT, FL_UNAUTH} fpss_flash_e;
  typedef enum logic {ST_NAVIGATE, ST_ROTATE} fpss_state_e;
endpackage

// File: hdl/fpss_front_panel.sv
// Front panel status sequencer: lamps, key decode, setpoint edit gate, idle rotation.
// Assumes synchronous level inputs from keypad, protection core and serial receiver,
// and an APB master with 32-bit data.
// Overview of operation
// - Any self-check abnormal condition operates the fault relay.
// - Fault relay is energised when idle and de-energised when operated.
// - Fault lamp lit exactly while the fault relay is operated.
// - Threshold lamp flashes on running overload or ground current over pickup.
// - Threshold lamp goes off once both currents are back under their settings.
// - Serial link lamp off when no serial data is seen.
// - Serial link lamp flashes when data arrives without valid addressed messages.
// - Serial link lamp steady while valid addressed messages keep arriving.
// - After 10 s without valid message the lamp falls to flash or off.
// - Configuration page key jumps to first message of next configuration page.
// - Measured page key jumps to first message of next measured page.
// - Commit saves edit only with programming enabled, then flashes acknowledgement.
// - Reset clears trip lamp and message only when cause is gone, else refuses.
// - Refusal shows lockout variant under overload lockout, otherwise fault variant.
// - Down moves toward page end, up toward start; header and footer shown.
// - Adjust toggles, steps list, or steps number clamped; holding repeats.
// - Headers carry two bars, page number and S or A prefix.
// - Keypad edit without access jumper refused with error; serial edits allowed.
// - After idle time without keys show first of up to five queued messages.
// - During idle rotation advance every 5 s when more than one queued.
// - Trip, alarm and flash messages override idle rotation.
// - Rotate in selection order; sixth entry drops the oldest.
module fpss_front_panel #(
  parameter int unsigned MS_CYCLES = 125000,
  parameter int unsigned NUM_SPAGES = 6,
  parameter int unsigned NUM_APAGES = 4,
  parameter int unsigned PAGE_LEN = 8,
  parameter int unsigned VAL_W = 16
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic self_fault,
  input wire logic phase_over_fl,
  input wire logic motor_running,
  input wire logic ground_over_pickup,
  input wire logic serial_activity,
  input wire logic serial_valid_msg,
  input wire logic trip_active,
  input wire logic trip_cause_present,
  input wire logic overload_lockout,
  input wire logic alarm_active,
  input wire logic access_jumper,
  input wire logic key_setpoint,
  input wire logic key_actual,
  input wire logic key_store,
  input wire logic key_reset,
  input wire logic key_msg_up,
  input wire logic key_msg_down,
  input wire logic key_val_up,
  input wire logic key_val_down,
  input wire logic [1:0] param_kind,
  input wire logic [VAL_W-1:0] param_val,
  input wire logic [VAL_W-1:0] param_max,
  input wire logic [VAL_W-1:0] param_step,
  input wire logic serial_edit_req,
  input wire logic [7:0] serial_edit_pos,
  input wire logic [VAL_W-1:0] serial_edit_val,
  output logic fault_relay_energize,
  output logic fault_lamp,
  output logic threshold_lamp,
  output logic serial_link_lamp,
  output logic trip_lamp,
  output logic trip_clear,
  output logic nv_write,
  output logic [7:0] nv_pos,
  output logic [VAL_W-1:0] nv_val,
  output logic [2:0] disp_src,
  output logic [2:0] disp_flash,
  output logic [7:0] disp_pos,
  output logic [VAL_W-1:0] disp_val,
  output logic disp_header,
  output logic disp_footer,
  output logic [15:0] disp_bars,
  output logic [7:0] disp_prefix
);
  localparam int unsigned MSW = $clog2(MS_CYCLES);
  localparam int unsigned LINK_MS = fpss_pkg::LINK_TIMEOUT_S * fpss_pkg::MS_PER_S;
  localparam int unsigned FLASH_MS = fpss_pkg::FLASH_S * fpss_pkg::MS_PER_S;

  // Refuse shapes that the 8-bit position code cannot carry
  if (PAGE_LEN < 3 || PAGE_LEN > 16 || NUM_SPAGES < 1 || NUM_SPAGES > 8 ||
      NUM_APAGES < 1 || NUM_APAGES > 8 || MS_CYCLES < 2 || VAL_W < 2) begin : g_bad
    $error("fpss_front_panel: unsupported parameter values");
  end

  // Wrap-around increment used for pages and list choices
  function automatic logic [VAL_W-1:0] wrap_inc(input logic [VAL_W-1:0] v,
                                                input logic [VAL_W-1:0] lim);
    wrap_inc = (v >= lim) ? '0 : v + 1'b1;
  endfunction

  // Millisecond enable, blink and second enables shared by every timer
  logic [MSW-1:0] ms_cnt_q;
  logic [9:0] ms_in_s_q;
  logic [9:0] blink_cnt_q;
  logic blink_q;
  wire ms_tick = (ms_cnt_q == MSW'(MS_CYCLES - 1));
  wire s_tick = ms_tick && (ms_in_s_q == 10'(fpss_pkg::MS_PER_S - 1));
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ms_cnt_q <= '0;
      ms_in_s_q <= '0;
      blink_cnt_q <= '0;
      blink_q <= 1'b0;
    end else begin
      ms_cnt_q <= ms_tick ? '0 : ms_cnt_q + 1'b1;
      if (ms_tick) begin
        ms_in_s_q <= s_tick ? '0 : ms_in_s_q + 1'b1;
        if (blink_cnt_q == 10'(fpss_pkg::BLINK_HALF_MS - 1)) begin
          blink_cnt_q <= '0;
          blink_q <= ~blink_q;
        end else begin
          blink_cnt_q <= blink_cnt_q + 1'b1;
        end
      end
    end
  end

  // Key edges; value keys also repeat while held
  logic [7:0] keys_q;
  logic [9:0] rept_q;
  wire [7:0] keys = {key_setpoint, key_actual, key_store, key_reset,
                     key_msg_up, key_msg_down, key_val_up, key_val_down};
  wire [7:0] key_edge = keys & ~keys_q;
  wire any_key = |key_edge;
  wire val_held = key_val_up | key_val_down;
  wire rept_fire = ms_tick && val_held && (rept_q == 10'(fpss_pkg::REPT_DELAY_MS));
  wire val_step = key_edge[1] | key_edge[0] | rept_fire;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      keys_q <= '0;
      rept_q <= '0;
    end else begin
      keys_q <= keys;
      if (!val_held || key_edge[1] || key_edge[0]) begin
        rept_q <= '0;
      end else if (rept_fire) begin
        rept_q <= 10'(fpss_pkg::REPT_DELAY_MS - fpss_pkg::REPT_RATE_MS);
      end else if (ms_tick) begin
        rept_q <= rept_q + 1'b1;
      end
    end
  end

  // Status lamps; relay and lamp share one flop so they never disagree
  logic fault_q;
  logic thresh_q;
  logic [13:0] link_ms_q;
  wire link_ok = (link_ms_q != '0);
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      fault_q <= 1'b0;
      thresh_q <= 1'b0;
      link_ms_q <= '0;
      threshold_lamp <= 1'b0;
      serial_link_lamp <= 1'b0;
      trip_lamp <= 1'b0;
    end else begin
      fault_q <= self_fault;
      thresh_q <= (phase_over_fl & motor_running) | ground_over_pickup;
      if (serial_valid_msg) begin
        link_ms_q <= 14'(LINK_MS);
      end else if (ms_tick && link_ok) begin
        link_ms_q <= link_ms_q - 1'b1;
      end
      threshold_lamp <= thresh_q & blink_q;
      serial_link_lamp <= link_ok | (serial_activity & blink_q);
      trip_lamp <= trip_active & blink_q;
    end
  end
  assign fault_relay_energize = ~fault_q;
  assign fault_lamp = fault_q;

  // Navigation position: mode, page and message index
  logic mode_q;
  logic [2:0] page_q;
  logic [3:0] idx_q;
  wire [7:0] cur_pos = {mode_q, page_q, idx_q};
  wire [2:0] last_s = 3'(NUM_SPAGES - 1);
  wire [2:0] last_a = 3'(NUM_APAGES - 1);
  wire [3:0] last_idx = 4'(PAGE_LEN - 1);
  wire [VAL_W-1:0] next_s = wrap_inc(VAL_W'(page_q), VAL_W'(last_s));
  wire [VAL_W-1:0] next_a = wrap_inc(VAL_W'(page_q), VAL_W'(last_a));
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      mode_q <= 1'b0;
      page_q <= '0;
      idx_q <= '0;
    end else if (key_edge[7]) begin
      mode_q <= 1'b0;
      page_q <= mode_q ? '0 : next_s[2:0];
      idx_q <= '0;
    end else if (key_edge[6]) begin
      mode_q <= 1'b1;
      page_q <= mode_q ? next_a[2:0] : '0;
      idx_q <= '0;
    end else if (key_edge[3] && idx_q != '0) begin
      idx_q <= idx_q - 1'b1;
    end else if (key_edge[2] && idx_q != last_idx) begin
      idx_q <= idx_q + 1'b1;
    end
  end

  // Setpoint edit buffer follows the shown value until an adjust key touches it
  logic dirty_q;
  logic [VAL_W-1:0] edit_q;
  wire edit_ok = access_jumper;
  wire [VAL_W+1:0] sum_w = {2'b00, edit_q} + {2'b00, param_step};
  wire [VAL_W-1:0] up_w = (sum_w > {2'b00, param_max}) ? param_max : sum_w[VAL_W-1:0];
  wire [VAL_W-1:0] dn_w = (edit_q > param_step) ? edit_q - param_step : '0;
  wire [VAL_W-1:0] list_w = wrap_inc(edit_q, param_max);
  wire navigated = |{key_edge[7:6], key_edge[4:2]};
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      dirty_q <= 1'b0;
      edit_q <= '0;
    end else if (navigated || key_edge[5]) begin
      dirty_q <= 1'b0;
      edit_q <= param_val;
    end else if (val_step && edit_ok && mode_q == 1'b0) begin
      dirty_q <= 1'b1;
      case (param_kind)
        fpss_pkg::KIND_YESNO: edit_q <= {edit_q[VAL_W-1:1], ~edit_q[0]};
        fpss_pkg::KIND_LIST: edit_q <= list_w;
        fpss_pkg::KIND_NUM: edit_q <= key_val_up ? up_w : dn_w;
        default: edit_q <= edit_q;
      endcase
    end else if (!dirty_q) begin
      edit_q <= param_val;
    end
  end

  // Commit, reset and refusal decisions
  wire commit = key_edge[5] && dirty_q && edit_ok;
  wire refuse_edit = val_step && !edit_ok && mode_q == 1'b0;
  wire rst_clear = key_edge[4] && trip_active && !trip_cause_present;
  wire rst_refuse = key_edge[4] && trip_active && trip_cause_present;
  wire queue_add = key_edge[5] && !dirty_q;

  // Non-volatile write port; serial edits bypass the jumper
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      nv_write <= 1'b0;
      nv_pos <= '0;
      nv_val <= '0;
      trip_clear <= 1'b0;
    end else begin
      nv_write <= commit | serial_edit_req;
      if (commit) begin
        nv_pos <= cur_pos;
        nv_val <= edit_q;
      end else if (serial_edit_req) begin
        nv_pos <= serial_edit_pos;
        nv_val <= serial_edit_val;
      end
      trip_clear <= rst_clear;
    end
  end

  // Flash message with its own display time
  fpss_pkg::fpss_flash_e flash_q;
  logic [11:0] flash_ms_q;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      flash_q <= fpss_pkg::FL_NONE;
      flash_ms_q <= '0;
    end else if (commit || refuse_edit || rst_refuse) begin
      flash_ms_q <= 12'(FLASH_MS);
      if (commit) begin
        flash_q <= fpss_pkg::FL_ACK;
      end else if (refuse_edit) begin
        flash_q <= fpss_pkg::FL_UNAUTH;
      end else if (overload_lockout) begin
        flash_q <= fpss_pkg::FL_LOCKOUT;
      end else begin
        flash_q <= fpss_pkg::FL_FAULT;
      end
    end else if (ms_tick && flash_ms_q != '0) begin
      flash_ms_q <= flash_ms_q - 1'b1;
      if (flash_ms_q == 12'h001) begin
        flash_q <= fpss_pkg::FL_NONE;
      end
    end
  end

  // Idle message queue; a full queue shifts out its oldest entry
  logic [7:0] queue_q [fpss_pkg::QUEUE_DEPTH];
  logic [2:0] qcnt_q;
  wire q_full = (qcnt_q == 3'(fpss_pkg::QUEUE_DEPTH));
  logic [31:0] ctrl_q;
  logic q_clear;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      qcnt_q <= '0;
      for (int i = 0; i < fpss_pkg::QUEUE_DEPTH; i++) queue_q[i] <= '0;
    end else if (q_clear) begin
      qcnt_q <= '0;
    end else if (queue_add) begin
      if (q_full) begin
        for (int i = 0; i < fpss_pkg::QUEUE_DEPTH - 1; i++) queue_q[i] <= queue_q[i+1];
        queue_q[fpss_pkg::QUEUE_DEPTH-1] <= cur_pos;
      end else begin
        queue_q[qcnt_q] <= cur_pos;
        qcnt_q <= qcnt_q + 1'b1;
      end
    end
  end

  // Idle timer and rotation; zero idle time turns rotation off
  fpss_pkg::fpss_state_e state_q;
  logic [7:0] idle_s_q;
  logic [2:0] rot_s_q;
  logic [2:0] rd_q;
  wire idle_due = (ctrl_q[7:0] != '0) && (idle_s_q >= ctrl_q[7:0]) && (qcnt_q != '0);
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= fpss_pkg::ST_NAVIGATE;
      idle_s_q <= '0;
      rot_s_q <= '0;
      rd_q <= '0;
    end else if (any_key || q_clear) begin
      state_q <= fpss_pkg::ST_NAVIGATE;
      idle_s_q <= '0;
    end else begin
      if (s_tick && idle_s_q != 8'hFF) begin
        idle_s_q <= idle_s_q + 1'b1;
      end
      case (state_q)
        fpss_pkg::ST_NAVIGATE: begin
          if (idle_due) begin
            state_q <= fpss_pkg::ST_ROTATE;
            rd_q <= '0;
            rot_s_q <= '0;
          end
        end
        fpss_pkg::ST_ROTATE: begin
          if (s_tick) begin
            if (rot_s_q == 3'(fpss_pkg::IDLE_STEP_S - 1)) begin
              rot_s_q <= '0;
              rd_q <= (rd_q + 1'b1 >= qcnt_q) ? '0 : rd_q + 1'b1;
            end else begin
              rot_s_q <= rot_s_q + 1'b1;
            end
          end
        end
        default: state_q <= fpss_pkg::ST_NAVIGATE;
      endcase
    end
  end

  // Display source by priority, then the shown position
  fpss_pkg::fpss_src_e src_w;
  assign src_w = trip_active ? fpss_pkg::SRC_TRIP :
                 alarm_active ? fpss_pkg::SRC_ALARM :
                 (flash_q != fpss_pkg::FL_NONE) ? fpss_pkg::SRC_FLASH :
                 (state_q == fpss_pkg::ST_ROTATE) ? fpss_pkg::SRC_IDLE :
                 fpss_pkg::SRC_NAV;
  wire [7:0] show_pos = (state_q == fpss_pkg::ST_ROTATE) ? queue_q[rd_q] : cur_pos;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      disp_src <= '0;
      disp_flash <= '0;
      disp_pos <= '0;
      disp_val <= '0;
      disp_header <= 1'b0;
      disp_footer <= 1'b0;
      disp_bars <= '0;
      disp_prefix <= '0;
    end else begin
      disp_src <= src_w;
      disp_flash <= flash_q;
      disp_pos <= show_pos;
      disp_val <= edit_q;
      disp_header <= (show_pos[3:0] == '0);
      disp_footer <= (show_pos[3:0] == last_idx);
      disp_bars <= (show_pos[3:0] == '0) ? {fpss_pkg::CHAR_BAR, fpss_pkg::CHAR_BAR} : '0;
      disp_prefix <= show_pos[7] ? fpss_pkg::CHAR_MEAS : fpss_pkg::CHAR_SETPT;
    end
  end

  // APB slave: zero wait states, error on unmapped offsets
  wire acc = psel && penable;
  wire hit_ctrl = (paddr == fpss_pkg::OFS_CTRL);
  wire hit_stat = (paddr == fpss_pkg::OFS_STATUS);
  wire hit_queue = (paddr == fpss_pkg::OFS_QUEUE);
  wire hit_pos = (paddr == fpss_pkg::OFS_POS);
  wire mapped = hit_ctrl | hit_stat | hit_queue | hit_pos;
  assign q_clear = acc && pwrite && hit_queue && pstrb[0] && pwdata[fpss_pkg::QU_CLEAR];
  wire [31:0] stat_w = (32'(fault_q) << fpss_pkg::ST_FAULT) |
                       (32'(thresh_q) << fpss_pkg::ST_THRESH) |
                       (32'(link_ok) << fpss_pkg::ST_LINK_OK) |
                       (32'(state_q) << fpss_pkg::ST_IDLE) |
                       (32'(src_w) << fpss_pkg::ST_SRC) |
                       (32'(flash_q) << fpss_pkg::ST_FLASH);
  wire [31:0] rd_w = hit_ctrl ? ctrl_q :
                     hit_stat ? stat_w :
                     hit_queue ? (32'(qcnt_q) << fpss_pkg::QU_COUNT) :
                     hit_pos ? 32'(cur_pos) : '0;
  assign pready = 1'b1;
  assign pslverr = acc && !mapped;
  assign prdata = (acc && !pwrite) ? rd_w : '0;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_q <= 32'(fpss_pkg::CTRL_RESET);
    end else if (acc && pwrite && hit_ctrl && pstrb[0]) begin
      ctrl_q <= {24'h00_0000, pwdata[7:0]};
    end
  end
endmodule

// File: dv/fpss_partner.sv
// Serial master model: silent, garbage only, or periodic valid addressed messages.
// Assumes the bench picks the mode; message spacing is short against the link timeout.
module fpss_partner (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [1:0] link_mode,
  output logic serial_activity,
  output logic serial_valid_msg
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [9:0] gap_q;
  // One valid message pulse every 1024 cycles in mode 2
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      gap_q <= 10'h000;
      serial_valid_msg <= 1'b0;
    end else begin
      gap_q <= gap_q + 10'h001;
      serial_valid_msg <= (link_mode == 2'h2) && (gap_q == 10'h000);
    end
  end
  // Line activity seen in both traffic modes
  assign serial_activity = (link_mode != 2'h0);
endmodule

// File: dv/fpss_chk_chk.sv
// Concurrent checks on the front panel sequencer ports.
// Assumes one clock domain and an asynchronous active-low reset.
module fpss_chk (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic self_fault,
  input wire logic phase_over_fl,
  input wire logic motor_running,
  input wire logic ground_over_pickup,
  input wire logic serial_valid_msg,
  input wire logic access_jumper,
  input wire logic key_setpoint,
  input wire logic serial_edit_req,
  input wire logic [7:0] serial_edit_pos,
  input wire logic fault_relay_energize,
  input wire logic fault_lamp,
  input wire logic threshold_lamp,
  input wire logic serial_link_lamp,
  input wire logic nv_write,
  input wire logic [7:0] nv_pos,
  input wire logic [7:0] disp_pos,
  input wire logic disp_header,
  input wire logic [15:0] disp_bars,
  input wire logic [7:0] disp_prefix
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking dc @(posedge clk);
  endclocking
  default disable iff (!rst_b);
  logic over_limit;
  // Running overload or ground excess
  assign over_limit = (phase_over_fl && motor_running) || ground_over_pickup;
  // Relay and lamp follow self-check; lamp must never disagree with relay
  AST_FAULT_OPERATE: assert property (self_fault |-> ##[1:2] !fault_relay_energize)
    else $error("fault relay energised after self-check fault");
  AST_FAILSAFE: assert property (!self_fault [*3] |-> fault_relay_energize)
    else $error("fault relay dropped without fault");
  AST_LAMP_MATCH: assert property (fault_lamp == !fault_relay_energize)
    else $error("fault lamp disagrees with relay");
  AST_THRESH_OFF: assert property (!over_limit [*3] |-> !threshold_lamp)
    else $error("threshold lamp lit with currents normal");
  AST_LINK_STEADY: assert property (serial_valid_msg |-> ##[1:2] serial_link_lamp)
    else $error("link lamp dark after valid message");
  // Page key lands on the header of a setpoint page two edges later
  AST_SETPT_PAGE: assert property ($rose(key_setpoint) |-> ##2
    disp_header && disp_pos[3:0] == 4'h0 && !disp_pos[7])
    else $error("setpoint key missed page start");
  AST_HEADER_BARS: assert property (disp_header |-> disp_bars == 16'h7C7C &&
    disp_prefix == (disp_pos[7] ? fpss_pkg::CHAR_MEAS : fpss_pkg::CHAR_SETPT))
    else $error("header bars or prefix wrong");
  // Keypad writes need the jumper; serial writes do not
  AST_STORE_GATE: assert property (nv_write |->
    $past(serial_edit_req) || $past(access_jumper))
    else $error("store without jumper or serial request");
  AST_SERIAL_EDIT: assert property (serial_edit_req |=>
    nv_write && nv_pos == $past(serial_edit_pos))
    else $error("serial edit not written");
  COV_HEADER_A: cover property (disp_header && disp_pos[7]);
  COV_NV: cover property (nv_write);
  COV_LINK: cover property ($rose(serial_link_lamp));
endmodule
bind fpss_front_panel fpss_chk fpss_chk_i (.clk, .rst_b, .self_fault, .phase_over_fl,
  .motor_running, .ground_over_pickup, .serial_valid_msg, .access_jumper, .key_setpoint,
  .serial_edit_req, .serial_edit_pos, .fault_relay_energize, .fault_lamp, .threshold_lamp,
  .serial_link_lamp, .nv_write, .nv_pos, .disp_pos, .disp_header, .disp_bars, .disp_prefix);

// File: dv/tb_top.sv
// Self-checking bench of the front panel sequencer: APB, lamps, keys, idle queue.
// Assumes zero-wait APB and a millisecond shortened to 2 cycles.
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int SEC = 2000;
  logic clk = 0, rst_b = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, err;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic self_fault = 0, phase_over_fl = 0, motor_running = 0, ground_over_pickup = 0;
  logic trip_active = 0, trip_cause_present = 0, overload_lockout = 0, alarm_active = 0;
  logic access_jumper = 0, serial_edit_req = 0, seen0, seen1, serial_activity;
  logic serial_valid_msg, fault_relay_energize, fault_lamp, threshold_lamp, serial_link_lamp;
  logic trip_lamp, trip_clear, nv_write, disp_header, disp_footer;
  logic [7:0] keys = 0, serial_edit_pos = 0, nv_pos, disp_pos, disp_prefix;
  logic [15:0] serial_edit_val = 0, nv_val, disp_val, disp_bars;
  logic [2:0] disp_src, disp_flash;
  logic [1:0] link_mode = 0;
  int mismatches = 0, num_checks = 0;
  always #4 clk = ~clk; // 125 MHz
  fpss_front_panel #(.MS_CYCLES(2)) fpss_front_panel_i (.clk, .rst_b, .paddr, .psel,
    .penable, .pwrite, .pwdata, .pstrb(4'hF), .prdata, .pready, .pslverr, .self_fault,
    .phase_over_fl, .motor_running, .ground_over_pickup, .serial_activity, .serial_valid_msg,
    .trip_active, .trip_cause_present, .overload_lockout, .alarm_active, .access_jumper,
    .key_setpoint(keys[0]), .key_actual(keys[1]), .key_store(keys[2]), .key_reset(keys[3]),
    .key_msg_up(keys[4]), .key_msg_down(keys[5]), .key_val_up(keys[6]),
    .key_val_down(keys[7]), .param_kind(fpss_pkg::KIND_NUM), .param_val(16'h0005),
    .param_max(16'h0009), .param_step(16'h0001), .serial_edit_req, .serial_edit_pos,
    .serial_edit_val, .fault_relay_energize, .fault_lamp, .threshold_lamp, .serial_link_lamp,
    .trip_lamp, .trip_clear, .nv_write, .nv_pos, .nv_val, .disp_src, .disp_flash, .disp_pos,
    .disp_val, .disp_header, .disp_footer, .disp_bars, .disp_prefix);
  fpss_partner fpss_partner_i (.clk, .rst_b, .link_mode, .serial_activity, .serial_valid_msg);
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // One APB transfer; held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic press(input int k);
    @(posedge clk);
    keys[k] <= 1'b1;
    repeat (3) @(posedge clk);
    keys[k] <= 1'b0;
    @(posedge clk);
  endtask
  // Records whether a lamp was seen off and on; blinking shows both
  task automatic scan(input bit link, input int n);
    seen0 = 0;
    seen1 = 0;
    repeat (4) @(posedge clk);
    repeat (n) begin
      @(posedge clk);
      if ((link ? serial_link_lamp : threshold_lamp) === 1'b1) seen1 = 1;
      else seen0 = 1;
    end
  endtask
  task automatic finish_test;
    if (mismatches == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    apb(0, fpss_pkg::OFS_CTRL, 32'h0);
    chk(rd, {24'h00_0000, fpss_pkg::CTRL_RESET});
    apb(0, 12'h010, 32'h0);
    chk({err, rd[30:0]}, 32'h8000_0000);
    self_fault <= 1'b1;
    repeat (3) @(posedge clk);
    chk({fault_relay_energize, fault_lamp}, 32'h1);
    apb(0, fpss_pkg::OFS_STATUS, 32'h0);
    chk(rd[fpss_pkg::ST_FAULT], 32'h1);
    self_fault <= 1'b0;
    // Threshold lamp: ground excess, then running overload, then clear
    ground_over_pickup <= 1'b1;
    scan(0, 1200);
    chk({seen0, seen1}, 32'h3);
    ground_over_pickup <= 1'b0;
    phase_over_fl <= 1'b1;
    motor_running <= 1'b1;
    scan(0, 1200);
    chk({seen0, seen1}, 32'h3);
    motor_running <= 1'b0;
    scan(0, 20);
    chk({seen0, seen1}, 32'h2);
    // Link lamp: valid traffic, then garbage past the timeout, then silence
    link_mode <= 2'h2;
    repeat (1100) @(posedge clk);
    scan(1, 3000);
    chk({seen0, seen1}, 32'h1);
    link_mode <= 2'h1;
    repeat (10 * SEC + 100) @(posedge clk);
    scan(1, 1200);
    chk({seen0, seen1}, 32'h3);
    link_mode <= 2'h0;
    scan(1, 20);
    chk({seen0, seen1}, 32'h2);
    // Page keys, navigation, header and footer
    press(1);
    chk({disp_prefix, disp_bars, disp_pos}, {fpss_pkg::CHAR_MEAS, 16'h7C7C, 8'h80});
    press(5);
    chk({disp_header, disp_pos}, 32'h81);
    press(1);
    press(4);
    chk(disp_pos, 32'h90);
    repeat (8) press(5);
    chk({disp_footer, disp_pos}, 32'h197);
    press(0);
    press(5);
    press(0);
    chk({disp_prefix, disp_pos}, {fpss_pkg::CHAR_SETPT, 8'h10});
    // Edits: refused without jumper, saved with it, serial needs none
    press(5);
    press(7);
    press(2);
    chk({disp_src, disp_flash}, {fpss_pkg::SRC_FLASH, fpss_pkg::FL_UNAUTH});
    access_jumper <= 1'b1;
    press(6);
    chk(disp_val, 32'h6);
    press(2);
    chk(disp_flash, fpss_pkg::FL_ACK);
    access_jumper <= 1'b0;
    serial_edit_pos <= 8'h23;
    serial_edit_val <= 16'h0042;
    serial_edit_req <= 1'b1;
    @(posedge clk);
    serial_edit_req <= 1'b0;
    @(posedge clk);
    chk({nv_write, nv_pos, nv_val}, 32'h0123_0042);
    // Reset key: refused twice, then clears
    trip_active <= 1'b1;
    trip_cause_present <= 1'b1;
    overload_lockout <= 1'b1;
    press(3);
    chk(disp_flash, fpss_pkg::FL_LOCKOUT);
    overload_lockout <= 1'b0;
    press(3);
    chk(disp_flash, fpss_pkg::FL_FAULT);
    trip_cause_present <= 1'b0;
    seen1 = 0;
    keys[3] <= 1'b1;
    repeat (4) begin
      @(posedge clk);
      seen1 |= trip_clear;
    end
    keys[3] <= 1'b0;
    trip_active <= 1'b0;
    chk(seen1, 32'h1);
    // Idle queue: overflow keeps five, then two rotate
    press(1);
    repeat (6) begin
      press(5);
      press(2);
    end
    apb(0, fpss_pkg::OFS_QUEUE, 32'h0);
    chk(rd[2:0], 32'h5);
    apb(1, fpss_pkg::OFS_QUEUE, 32'h1);
    apb(0, fpss_pkg::OFS_QUEUE, 32'h0);
    chk(rd[2:0], 32'h0);
    repeat (2) begin
      press(4); // Distinct entries 0x85 then 0x84
      press(2);
    end
    apb(1, fpss_pkg::OFS_CTRL, 32'h1);
    repeat (4 * SEC) @(posedge clk);
    chk(disp_src, fpss_pkg::SRC_IDLE);
    chk(disp_pos, 32'h85);
    repeat (5 * SEC + 100) @(posedge clk);
    chk(disp_pos, 32'h84);
    alarm_active <= 1'b1;
    repeat (3) @(posedge clk);
    chk(disp_src, fpss_pkg::SRC_ALARM);
    alarm_active <= 1'b0;
    press(5);
    chk(disp_src, fpss_pkg::SRC_NAV);
    finish_test;
  end
  // Watchdog well beyond the expected run
  initial begin
    repeat (90000) @(posedge clk);
    mismatches++;
    finish_test;
  end
endmodule
